// >>> core/psbi_regs.vh
// constants for the system bus controller (external agent side)
// Contract
// (R01) address and data share one 64-bit bus with an 8-bit check bus.
// (R02) processor check bus may be configured as parity or error-correcting code.
// (R03) 9-bit command bus; whoever drives it adds parity.
// (R04) command tells address or data; address commands give transaction type.
// (R05) data commands carry last-word marker and line cache state.
// (R06) command bus is two-way; each party drives its own requests.
// (R07) byte, halfword, tribyte, word, doubleword and block transfers are supported.
// (R08) sub-doubleword: low three address bits give byte, command gives count.
// (R09) processor transmit rate and frequency come from boot-time mode bits.
// (R10) external agent alone paces data into the processor.
// (R11) agent drives read and write accept-ready to show it can accept.
// (R12) processor samples accept-ready before removing the address.
// (R13) agent asserts external_bus_request to ask for bus ownership.
// (R14) processor answers with release, handing buses to the agent.
// (R15) processor_valid marks every cycle the processor drives valid content.
// (R16) agent asserts external_valid only while owning and driving valid content.
// (R17) agent reports invalidate completion with invalidate_ack or invalidate_error.
// (R18) processor has modes with and without secondary cache.
// (R19) without secondary cache, one processor request outstanding at a time.
// (R20) read: valid with address; if read-ready, processor tristates and releases.
// (R21) with secondary cache, processor may overlap transactions.
// (R22) during handover the processor keeps its drivers tristated.
`ifndef PSBI_REGS_VH
`define PSBI_REGS_VH
// ************************************************************
// register map of the controller
// ************************************************************
`define PSBI_A_CTRL 4'h0
`define PSBI_A_STAT 4'h1
`define PSBI_A_REQ 4'h2
`define PSBI_A_ADDR 4'h3
`define PSBI_A_DATA 4'h4
`define PSBI_A_CAPA 4'h5
`define PSBI_A_CAPC 4'h6
// ctrl fields
`define PSBI_C_RRDY 0
`define PSBI_C_WRDY 1
`define PSBI_C_ECC 2
`define PSBI_C_IVACK 3
`define PSBI_C_IVERR 4
// req fields: bit 0 go, bits 9:1 command, bit 10 last of burst
`define PSBI_R_GO 0
`define PSBI_R_CMD_HI 9
`define PSBI_R_CMD_LO 1
`define PSBI_R_LAST 10
// status fields
`define PSBI_S_OWN 0
`define PSBI_S_BUSY 1
`define PSBI_S_CAP 2
`define PSBI_S_PERR 3
`define PSBI_S_CERR 4
`define PSBI_S_CCNT_LO 8
// command encoding: bit 8 set marks data, 7:5 type / state
`define PSBI_CMD_DATA 8
`define PSBI_CMD_LAST 7
// states
`define PSBI_ST_IDLE 3'h0
`define PSBI_ST_ASK 3'h1
`define PSBI_ST_OWN 3'h2
`define PSBI_ST_SEND 3'h3
`define PSBI_ST_BACK 3'h4
`define PSBI_W 64
`define PSBI_CW 9
`endif

// >>> core/psbi_agent.v
// external agent controller joining software to the processor system bus
//
// The address map and strobed register access were chosen for this implementation.
`include "psbi_regs.vh"
module psbi_agent (
  input wire clk,
  input wire reset_n,
  input wire [3:0] addr,
  input wire [63:0] wdata,
  input wire wr,
  input wire rd,
  output reg [63:0] rdata,
  input wire [63:0] sys_addr_data_bus_in,
  output reg [63:0] sys_addr_data_bus_out,
  output wire sys_addr_data_bus_oe_n,
  input wire [7:0] sys_check_bus_in,
  output reg [7:0] sys_check_bus_out,
  output wire sys_check_bus_oe_n,
  input wire [8:0] sys_command_bus_in,
  input wire sys_command_parity_in,
  output reg [8:0] sys_command_bus_out,
  output reg sys_command_parity_out,
  output wire sys_command_bus_oe_n,
  input wire processor_valid,
  input wire release_bus,
  output wire read_accept_ready,
  output wire write_accept_ready,
  output reg external_bus_request,
  output reg external_valid,
  output wire invalidate_ack,
  output wire invalidate_error
);
  reg [4:0] ctrl_q;
  reg [2:0] state_q;
  reg [63:0] cap_addr_q;
  reg [8:0] cap_cmd_q;
  reg cap_q;
  reg perr_q;
  reg cerr_q;
  reg [7:0] ccnt_q;
  reg [63:0] tx_data_q;
  reg [10:0] tx_req_q;
  reg pend_q;
  reg [7:0] chk;
  integer i;
  wire own;
  wire take_req;
  wire cap_ev;
  wire cap_clr;

  // ************************************************************
  // readiness and status outputs
  // ************************************************************
  // software chooses whether the processor may hand us new work
  assign read_accept_ready = ctrl_q[`PSBI_C_RRDY]; // R11
  assign write_accept_ready = ctrl_q[`PSBI_C_WRDY]; // R11
  // one-cycle completion pulses for invalidate requests: acknowledge and error
  assign invalidate_ack = ctrl_q[`PSBI_C_IVACK]; // R17
  assign invalidate_error = ctrl_q[`PSBI_C_IVERR]; // R17
  // we drive the shared buses only while the processor has released them
  assign own = (state_q == `PSBI_ST_OWN) || (state_q == `PSBI_ST_SEND);
  assign sys_addr_data_bus_oe_n = ~own; // R06
  assign sys_check_bus_oe_n = ~own;
  assign sys_command_bus_oe_n = ~own; // R06

  // check bits for the outgoing word: byte parity or a folded code
  always @* begin
    chk = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      chk[i] = ^tx_data_q[i*8 +: 8];
    end
    if (ctrl_q[`PSBI_C_ECC]) begin
      chk = chk ^ {tx_data_q[7:0] ^ tx_data_q[63:56]}; // R02
    end
  end

  // ************************************************************
  // capture of processor commands and data
  // ************************************************************
  // we take whatever arrives whenever valid is high and we do not own the buses; the processor paces only its own sends
  assign cap_ev = processor_valid && !own; // R15
  assign cap_clr = wr && (addr == `PSBI_A_STAT);
  // capture flag: a new word wins over a clear in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_q <= 1'b0;
      perr_q <= 1'b0;
      cerr_q <= 1'b0;
      ccnt_q <= 8'h00;
      cap_addr_q <= 64'h0000000000000000;
      cap_cmd_q <= 9'h000;
    end else begin
      if (cap_ev) begin
        cap_q <= 1'b1;
        cap_addr_q <= sys_addr_data_bus_in; // R01 R08
        cap_cmd_q <= sys_command_bus_in; // R04
        ccnt_q <= ccnt_q + 8'h01;
        // parity error on the command bus from the processor
        if ((^sys_command_bus_in) != sys_command_parity_in) begin
          perr_q <= 1'b1; // R03
        end
        if (!ctrl_q[`PSBI_C_ECC] && (sys_check_bus_in != {
            ^sys_addr_data_bus_in[63:56], ^sys_addr_data_bus_in[55:48],
            ^sys_addr_data_bus_in[47:40], ^sys_addr_data_bus_in[39:32],
            ^sys_addr_data_bus_in[31:24], ^sys_addr_data_bus_in[23:16],
            ^sys_addr_data_bus_in[15:8], ^sys_addr_data_bus_in[7:0]})) begin
          cerr_q <= 1'b1; // R01
        end
      end else if (cap_clr) begin
        cap_q <= cap_q & ~wdata[`PSBI_S_CAP];
        perr_q <= perr_q & ~wdata[`PSBI_S_PERR];
        cerr_q <= cerr_q & ~wdata[`PSBI_S_CERR];
      end
    end
  end

  // ************************************************************
  // control register and request latch
  // ************************************************************
  assign take_req = wr && (addr == `PSBI_A_REQ) && wdata[`PSBI_R_GO];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 5'h00;
      tx_data_q <= 64'h0000000000000000;
      tx_req_q <= 11'h000;
      pend_q <= 1'b0;
    end else begin
      // invalidate status bits self-clear so they act as pulses
      ctrl_q[`PSBI_C_IVACK] <= 1'b0;
      ctrl_q[`PSBI_C_IVERR] <= 1'b0;
      if (wr && (addr == `PSBI_A_CTRL)) begin
        ctrl_q <= wdata[4:0];
      end
      if (wr && (addr == `PSBI_A_DATA)) begin
        tx_data_q <= wdata;
      end
      // a new word is refused while one is pending
      if (take_req && !pend_q) begin
        tx_req_q <= wdata[10:0];
        pend_q <= 1'b1;
      end else if (state_q == `PSBI_ST_SEND) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // ownership state machine
  // ************************************************************
  // ask, wait for release, drive words until one marked last, then give the buses back
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= `PSBI_ST_IDLE;
      external_bus_request <= 1'b0;
      external_valid <= 1'b0;
      sys_addr_data_bus_out <= 64'h0000000000000000;
      sys_check_bus_out <= 8'h00;
      sys_command_bus_out <= 9'h000;
      sys_command_parity_out <= 1'b0;
    end else begin
      external_valid <= 1'b0;
      case (state_q)
        `PSBI_ST_IDLE: begin
          if (pend_q || release_bus) begin
            state_q <= release_bus ? `PSBI_ST_OWN : `PSBI_ST_ASK;
            external_bus_request <= !release_bus; // R13
          end
        end
        `PSBI_ST_ASK: begin
          // the processor answers with release before we touch the buses
          if (release_bus) begin
            external_bus_request <= 1'b0; // R14
            state_q <= `PSBI_ST_OWN; // R22
          end
        end
        `PSBI_ST_OWN: begin
          if (pend_q) begin
            sys_addr_data_bus_out <= tx_data_q; // R07
            sys_check_bus_out <= chk;
            sys_command_bus_out <= tx_req_q[`PSBI_R_CMD_HI:`PSBI_R_CMD_LO]; // R05
            sys_command_parity_out <= ^tx_req_q[`PSBI_R_CMD_HI:`PSBI_R_CMD_LO]; // R03
            external_valid <= 1'b1; // R16
            state_q <= `PSBI_ST_SEND;
          end else if (!release_bus) begin
            state_q <= `PSBI_ST_IDLE;
          end
        end
        `PSBI_ST_SEND: begin
          // we pace data into the processor one word per software push
          state_q <= tx_req_q[`PSBI_R_LAST] ? `PSBI_ST_BACK : `PSBI_ST_OWN; // R10
        end
        `PSBI_ST_BACK: begin
          state_q <= `PSBI_ST_IDLE;
        end
        default: begin
          state_q <= `PSBI_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 64'h0000000000000000;
    end else if (rd) begin
      case (addr)
        `PSBI_A_CTRL: rdata <= {59'h0, ctrl_q};
        `PSBI_A_STAT: rdata <= {48'h0, ccnt_q, 3'h0, cerr_q, perr_q, cap_q, pend_q, own};
        `PSBI_A_REQ: rdata <= {53'h0, tx_req_q};
        `PSBI_A_DATA: rdata <= tx_data_q;
        `PSBI_A_CAPA: rdata <= cap_addr_q;
        `PSBI_A_CAPC: rdata <= {55'h0, cap_cmd_q};
        default: rdata <= 64'h0000000000000000;
      endcase
    end else begin
      rdata <= 64'h0000000000000000;
    end
  end
endmodule // psbi_agent

// >>> verif/psbi_agent_properties.sv
// assertions on the system bus agent ports
`include "psbi_regs.vh"
module psbi_agent_properties (
  input wire clk,
  input wire reset_n,
  input wire [3:0] addr,
  input wire [63:0] wdata,
  input wire wr,
  input wire [8:0] sys_command_bus_out,
  input wire sys_command_parity_out,
  input wire sys_addr_data_bus_oe_n,
  input wire release_bus,
  input wire read_accept_ready,
  input wire external_bus_request,
  input wire external_valid,
  input wire invalidate_ack,
  input wire invalidate_error
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // software write to the control register
  wire cw = wr && addr == `PSBI_A_CTRL;
  property p_par; external_valid |-> sys_command_parity_out == ^sys_command_bus_out; endproperty
  a_par: assert property (p_par) else $error("bad parity");
  property p_own; external_valid |-> !sys_addr_data_bus_oe_n && release_bus; endproperty
  a_own: assert property (p_own) else $error("valid unowned");
  property p_one; external_valid |=> !external_valid; endproperty
  a_one: assert property (p_one) else $error("valid long");
  property p_take; $fell(sys_addr_data_bus_oe_n) |-> release_bus; endproperty
  a_take: assert property (p_take) else $error("early drive");
  property p_req; external_bus_request && release_bus |=> !external_bus_request; endproperty
  a_req: assert property (p_req) else $error("request held");
  property p_rdy; !$past(cw) |-> $stable(read_accept_ready); endproperty
  a_rdy: assert property (p_rdy) else $error("ready moved");
  property p_ack; invalidate_ack |-> $past(cw) && $past(wdata[`PSBI_C_IVACK]); endproperty
  a_ack: assert property (p_ack) else $error("stray ack");
  property p_err; invalidate_error |-> $past(cw) && $past(wdata[`PSBI_C_IVERR]); endproperty
  a_err: assert property (p_err) else $error("stray error");
  c_send: cover property (external_valid);
  c_take: cover property ($fell(sys_addr_data_bus_oe_n));
  c_ack: cover property (invalidate_ack);
endmodule // psbi_agent_properties
bind psbi_agent psbi_agent_properties u_psbi_agent_properties (.*);

// >>> verif/psbi_cpu_model.sv
// behavioural processor on the far side of the system bus
module psbi_cpu_model (
  input wire clk,
  input wire reset_n,
  input wire go,
  input wire [73:0] go_word,
  input wire external_bus_request,
  input wire sys_addr_data_bus_oe_n,
  input wire read_accept_ready,
  input wire write_accept_ready,
  output reg [73:0] cpu_drive_q,
  output reg processor_valid,
  output reg release_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  reg oe_q;
  // ****
  // requests and handover
  // ****
  // idle lines show the inverted last word, so stale data never matches
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {processor_valid, release_bus, oe_q, cpu_drive_q} <= {3'b001, 74'h0};
    end else begin
      // single rate, no secondary cache: one request at a time, never overlapped
      // a request only goes out while the agent shows it can take one
      processor_valid <= go & (read_accept_ready | write_accept_ready);
      cpu_drive_q <= go ? go_word : processor_valid ? ~cpu_drive_q : cpu_drive_q;
      oe_q <= sys_addr_data_bus_oe_n;
      // release holds until the agent lets go of the lines
      release_bus <= external_bus_request | (release_bus & ~(sys_addr_data_bus_oe_n & ~oe_q));
    end
  end
endmodule // psbi_cpu_model

// >>> verif/tb_processor_system_bus_interface.sv
// self-checking bench for the system bus agent
`include "psbi_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_processor_system_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, wr, rd, go, sys_addr_data_bus_oe_n, sys_check_bus_oe_n;
  logic sys_command_bus_oe_n, sys_command_parity_in, sys_command_parity_out, processor_valid;
  logic release_bus, read_accept_ready, write_accept_ready, external_bus_request;
  logic external_valid, invalidate_ack, invalidate_error;
  logic [3:0] addr;
  logic [7:0] sys_check_bus_in, sys_check_bus_out;
  logic [8:0] sys_command_bus_in, sys_command_bus_out;
  logic [63:0] wdata, rdata, v, sys_addr_data_bus_in, sys_addr_data_bus_out;
  logic [73:0] go_word, cpu_drive_q;
  int bad_count = 0, samples_checked = 0, i;
  psbi_agent u_psbi_agent (.*);
  psbi_cpu_model u_psbi_cpu_model (.*);
  // ****
  // wires, clock and tasks
  // ****
  function automatic [7:0] ckf(input [63:0] w);
    for (int b = 0; b < 8; b++) ckf[b] = ^w[8*b +: 8];
  endfunction
  // an enable held low means the agent owns the line
  assign sys_addr_data_bus_in = sys_addr_data_bus_oe_n ? cpu_drive_q[63:0] : sys_addr_data_bus_out;
  assign sys_check_bus_in = sys_check_bus_oe_n ? ckf(cpu_drive_q[63:0]) : sys_check_bus_out;
  assign {sys_command_parity_in, sys_command_bus_in} = sys_command_bus_oe_n ?
    cpu_drive_q[73:64] : {sys_command_parity_out, sys_command_bus_out};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one register access, w high for a write; read data lands in v
  task automatic acc(input w, input [3:0] a, input [63:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1 v = rdata;
  endtask
  // one agent word, caught in its single valid cycle
  task automatic send(input [63:0] d, input [8:0] c);
    acc(1, `PSBI_A_DATA, d);
    acc(1, `PSBI_A_REQ, {53'h0, c[7], c, 1'b1});
    for (i = 0; i < 20 && external_valid !== 1'b1; i++) @(posedge clk) #1;
    `CHK("data", d, sys_addr_data_bus_in)
    `CHK("cmd", {^c, c}, {sys_command_parity_in, sys_command_bus_in})
    `CHK("check", ckf(d), sys_check_bus_in)
  endtask
  task automatic stop_test;
    $display("checked %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000 bad_count++;
    stop_test();
  end
  initial begin
    {reset_n, wr, rd, go, addr, wdata, go_word} = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    acc(0, 4'hf, 64'h0);
    `CHK("unmapped", 64'h0, v)
    `CHK("idle", 1'b1, sys_addr_data_bus_oe_n)
    for (i = 0; i < 4; i++) begin
      acc(1, `PSBI_A_CTRL, 64'(i));
      `CHK("ready", i[1:0], {write_accept_ready, read_accept_ready})
    end
    // read, write, then a sub-doubleword carrying a bad parity bit
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      {go, go_word} <= {1'b1, ^9'(i * 33) ^ (i == 2), 9'(i * 33), 64'h85 + 64'(i)};
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      acc(0, `PSBI_A_CAPA, 64'h0);
      `CHK("cap addr", 64'h85 + 64'(i), v)
      acc(0, `PSBI_A_CAPC, 64'h0);
      `CHK("cap cmd", 9'(i * 33), v[8:0])
    end
    acc(0, `PSBI_A_STAT, 64'h0);
    `CHK("flags", 3'b011, v[4:2])
    `CHK("count", 8'h03, v[15:8])
    send(64'h0123_4567_89ab_cdef, 9'h100);
    acc(0, `PSBI_A_STAT, 64'h0);
    `CHK("owned", 1'b1, v[0])
    send(64'hfedc_ba98_7654_3210, 9'h180);
    repeat (3) @(posedge clk) #1;
    `CHK("handed back", 1'b1, sys_addr_data_bus_oe_n)
    acc(1, `PSBI_A_CTRL, 64'h8);
    `CHK("ack", 1'b1, invalidate_ack)
    acc(1, `PSBI_A_CTRL, 64'h10);
    `CHK("error", 1'b1, invalidate_error)
    stop_test();
  end
endmodule // tb_processor_system_bus_interface
